// file: rtl/brot_byte_rotate_unit.v
// What this block does
// - rotate left, write back, flags kept
// - rotate left into accumulator, memory kept
// - left through carry, write back memory
// - left through carry into accumulator
// - rotate right, write back, flags kept
// - rotate right into accumulator, memory kept
// - right through carry, write back memory
// - right through carry into accumulator

`timescale 1ns/1ns
`default_nettype none

`include "brot_defines.vh"

module brot_byte_rotate_unit #(
  parameter DATA_W = 8,
  parameter OP_W   = `BROT_OP_W
) (
  // clock and reset
  input  wire              clk_sys_i,
  input  wire              rst_b_i,
  // operands from the decoder
  input  wire              exec_i,
  input  wire [OP_W-1:0]   op_sel_i,
  input  wire              dest_sel_i,
  input  wire [DATA_W-1:0] operand_i,
  input  wire              carry_i,
  // results
  output reg  [DATA_W-1:0] result_o,
  output reg               carry_o,
  output reg               carry_we_o,
  output reg               mem_we_o,
  output reg               acc_we_o
);

  localparam TOP_BIT    = DATA_W - 1;
  localparam BOTTOM_BIT = `BROT_BIT_BOTTOM;

  // operation codes at the width of the select port
  localparam [OP_W-1:0] OP_LEFT        = `BROT_OP_ROT_LEFT;
  localparam [OP_W-1:0] OP_LEFT_CARRY  = `BROT_OP_ROT_LEFT_CARRY;
  localparam [OP_W-1:0] OP_RIGHT       = `BROT_OP_ROT_RIGHT;
  localparam [OP_W-1:0] OP_RIGHT_CARRY = `BROT_OP_ROT_RIGHT_CARRY;

  // the two variants that pull the carry flag into the ring
  function is_carry_op;
    input [OP_W-1:0] op;
    begin
      is_carry_op = (op == OP_LEFT_CARRY) ||
                    (op == OP_RIGHT_CARRY);
    end
  endfunction

  // bits move towards the top
  function is_left_op;
    input [OP_W-1:0] op;
    begin
      is_left_op = (op == OP_LEFT) ||
                   (op == OP_LEFT_CARRY);
    end
  endfunction

  // bits move towards the bottom
  function is_right_op;
    input [OP_W-1:0] op;
    begin
      is_right_op = (op == OP_RIGHT) ||
                    (op == OP_RIGHT_CARRY);
    end
  endfunction

  // result goes to the accumulator, memory byte untouched
  function is_accum_dest;
    input dest;
    begin
      is_accum_dest = (dest == `BROT_DEST_ACCUM);
    end
  endfunction

  // result written back over the memory byte
  function is_memory_dest;
    input dest;
    begin
      is_memory_dest = (dest == `BROT_DEST_MEMORY);
    end
  endfunction

  // operand with every bit moved one place, end bits filled below
  wire [DATA_W-1:0] shl_w;
  wire [DATA_W-1:0] shr_w;
  wire              left_fill_w;
  wire              right_fill_w;

  genvar g;
  generate
    // each bit above the bottom takes its lower neighbour
    for (g = 1; g < DATA_W; g = g + 1) begin : g_shift_up
      assign shl_w[g] = operand_i[g-1];
    end
    // each bit below the top takes its upper neighbour
    for (g = 0; g < TOP_BIT; g = g + 1) begin : g_shift_down
      assign shr_w[g] = operand_i[g+1];
    end
  endgenerate

  // plain rotates close the ring, through-carry ones insert the flag
  assign left_fill_w  = is_carry_op(op_sel_i) ? carry_i
                                              : operand_i[TOP_BIT];
  assign right_fill_w = is_carry_op(op_sel_i) ? carry_i
                                              : operand_i[BOTTOM_BIT];
  assign shl_w[BOTTOM_BIT] = left_fill_w;
  assign shr_w[TOP_BIT]    = right_fill_w;

  reg [DATA_W-1:0] result_d;
  reg              carry_d;
  reg              carry_we_d;
  reg              mem_we_d;
  reg              acc_we_d;

  // result picked by operation; unused codes pass the operand
  always @* begin
    result_d = operand_i;
    case (op_sel_i)
      OP_LEFT: begin
        result_d = shl_w;
      end
      OP_LEFT_CARRY: begin
        result_d = shl_w;
      end
      OP_RIGHT: begin
        result_d = shr_w;
      end
      OP_RIGHT_CARRY: begin
        result_d = shr_w;
      end
      default: begin
        // codes 4 to 7 leave the byte as it is
        result_d = operand_i;
      end
    endcase
  end

  // new carry: the bit that falls off the end of a through-carry rotate
  always @* begin
    carry_d = carry_i;
    if (is_carry_op(op_sel_i)) begin
      if (is_left_op(op_sel_i)) begin
        carry_d = operand_i[TOP_BIT];
      end else if (is_right_op(op_sel_i)) begin
        carry_d = operand_i[BOTTOM_BIT];
      end else begin
        carry_d = carry_i;
      end
    end
  end

  // only the through-carry variants may touch the flag
  always @* begin
    if (exec_i) begin
      carry_we_d = is_carry_op(op_sel_i);
      mem_we_d   = is_memory_dest(dest_sel_i);
      acc_we_d   = is_accum_dest(dest_sel_i);
    end else begin
      carry_we_d = 1'b0;
      mem_we_d   = 1'b0;
      acc_we_d   = 1'b0;
    end
  end

  // result takes the rotated operand on every edge, whatever exec_i is
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      result_o <= `BROT_RST_BYTE;
    end else begin
      result_o <= result_d;
    end
  end

  // carry shows the old flag unless a through-carry code is selected, even when exec_i is low
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      carry_o <= `BROT_RST_BIT;
    end else begin
      carry_o <= carry_d;
    end
  end

  // flag write strobe, one cycle
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      carry_we_o <= 1'b0;
    end else begin
      carry_we_o <= carry_we_d;
    end
  end

  // memory write strobe, one cycle
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mem_we_o <= 1'b0;
    end else begin
      mem_we_o <= mem_we_d;
    end
  end

  // accumulator write strobe, one cycle
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      acc_we_o <= 1'b0;
    end else begin
      acc_we_o <= acc_we_d;
    end
  end

endmodule

`default_nettype wire

// file: include/brot_defines.vh
`ifndef BROT_DEFINES_VH
`define BROT_DEFINES_VH

// operation select codes
`define BROT_OP_W              3
`define BROT_OP_ROT_LEFT       3'h0
`define BROT_OP_ROT_LEFT_CARRY 3'h1
`define BROT_OP_ROT_RIGHT      3'h2
`define BROT_OP_ROT_RIGHT_CARRY 3'h3

// destination select
`define BROT_DEST_MEMORY       1'h0
`define BROT_DEST_ACCUM        1'h1

// bit positions of the byte
`define BROT_BIT_TOP           7
`define BROT_BIT_BOTTOM        0

// reset values
`define BROT_RST_BYTE          8'h00
`define BROT_RST_BIT           1'h0

`endif

// file: testbench/brot_flag_model.sv
`timescale 1ns/1ns
`default_nettype none
module brot_flag_model(input wire clk_sys_i,carry_o,carry_we_o,
  output var logic carry_i=1'h0);
  always @(posedge clk_sys_i) if(carry_we_o) carry_i<=carry_o;
endmodule
`default_nettype wire

// file: testbench/brot_chk_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module brot_chk(input wire clk_sys_i,rst_b_i,exec_i,dest_sel_i,carry_i,
  input wire [2:0] op_sel_i,input wire [7:0] operand_i,result_o,
  input wire carry_o,carry_we_o,mem_we_o,acc_we_o);
  default clocking @(posedge clk_sys_i);endclocking
  default disable iff(!rst_b_i);
  wire [7:0] d=operand_i;
  wire [2:0] o=op_sel_i;
  a_rot_left:assert property(o==3'h0|=>
    result_o=={$past(d[6:0]),$past(d[7])}) else $error("rotate left");
  a_left_carry:assert property(o==3'h1|=>
    {carry_o,result_o}=={$past(d),$past(carry_i)}) else $error("left carry");
  a_rot_right:assert property(o==3'h2|=>
    result_o=={$past(d[0]),$past(d[7:1])}) else $error("rotate right");
  a_right_carry:assert property(o==3'h3|=>
    {result_o,carry_o}=={$past(carry_i),$past(d)}) else $error("right carry");
  a_write_sel:assert property(exec_i|=>
    acc_we_o==$past(dest_sel_i)&&mem_we_o!=acc_we_o
    &&carry_we_o==$past(o==3'h1||o==3'h3)) else $error("strobes");
  a_idle_quiet:assert property(!exec_i|=>
    !(mem_we_o|acc_we_o|carry_we_o)) else $error("idle");
  a_carry_kept:assert property(!(o==3'h1||o==3'h3)|=>
    carry_o==$past(carry_i)&&!carry_we_o) else $error("carry kept");
endmodule
bind brot_byte_rotate_unit brot_chk brot_chk_i(.*);
`default_nettype wire

// file: testbench/byte_rotate_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module byte_rotate_unit_tb;
  logic clk_sys_i=0,rst_b_i=0,exec_i=0,dest_sel_i=0;
  logic [2:0] op_sel_i=0;
  logic [7:0] operand_i=0;
  logic [31:0] r=32'h69928318;
  logic [11:0] x;
  wire [7:0] result_o;
  wire carry_i,carry_o,carry_we_o,mem_we_o,acc_we_o;
  int mismatches=0,n_tests=0;
  brot_byte_rotate_unit brot_byte_rotate_unit_i(.*);
  brot_flag_model brot_flag_model_i(.*);
  initial forever #50 clk_sys_i=~clk_sys_i;
  function automatic logic [9:0] ex(logic [2:0] o,logic c,logic [7:0] m);
    case(o)
      0:ex={m[6:0],m[7],c,1'h0};
      1:ex={m[6:0],c,m[7],1'h1};
      2:ex={m[0],m[7:1],c,1'h0};
      3:ex={c,m[7:1],m[0],1'h1};
      default:ex={m,c,1'h0};
    endcase
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] v);
    lfsr={v[30:0],v[31]^v[21]^v[1]^v[0]};
  endfunction
  task chk(logic [11:0] s,e);
    n_tests++;
    if(s!==e) begin
      mismatches++;
      $display("mismatch %0t got %h",$time,s);
    end
  endtask
  task conclude;
    $display("tests %0d mismatches %0d",n_tests,mismatches);
    if(mismatches==0&&n_tests>0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat(2) @(negedge clk_sys_i);
    chk({result_o,carry_o,carry_we_o,mem_we_o,acc_we_o},12'h000);
    rst_b_i=1;
    for(int i=0;i<300;i++) begin
      r=lfsr(r);
      {exec_i,op_sel_i,dest_sel_i,operand_i}=i<8?{1'h1,i[3:0],8'h81}:r[12:0];
      x={ex(op_sel_i,carry_i,operand_i)&{9'h1FF,exec_i},
        {~dest_sel_i,dest_sel_i}&{2{exec_i}}};
      @(negedge clk_sys_i);
      chk({result_o,carry_o,carry_we_o,mem_we_o,acc_we_o},x);
    end
    $display("rotate test done");
    conclude;
  end
endmodule
`default_nettype wire
